/* design/operand_decode_pkg.sv */
// How it works
// [RQ1] A 6-bit I/O short address becomes a full data address with every upper bit set to one.
// [RQ2] A 6-bit absolute short address becomes a full data address with every upper bit cleared.
// [RQ3] A 16-bit absolute address passes through unchanged and can reach any data location.
// [RQ4] The short branch offset is a 7-bit signed value added to the program counter to give the target.
// [RQ5] Short immediates are 7 bits for the load-immediate instruction and 6 bits for loop and repeat.
// [RQ6] An 8-bit mask lands in the upper or the lower byte of the 16-bit mask, the other byte being zero.
// [RQ7] The long immediate gives a full 16-bit data word and the long mask a full 16-bit mask.
// [RQ8] The arithmetic operand field picks one of two 36-bit accumulators or three 16-bit data registers.
// [RQ9] The general pointer field picks one of four pointers or the stack pointer.
// [RQ10] The restricted pointer field picks only one of the four pointers, never the stack pointer.
// [RQ11] The index register is an address operand only in the indexed addressing modes.
// [RQ12] The accumulator-pair operand encodes only first-with-second or second-with-first.
// [RQ13] The move field over data and address registers picks among seven ALU and five address registers.
// [RQ14] A register code outside the field's permitted set flags an illegal instruction and writes nothing.
package operand_decode_pkg;
  localparam int ADDR_W = 16;
  localparam int SHORT_ADDR_W = 6;
  localparam int BRANCH_OFS_W = 7;
  localparam int IMM_LOAD_W = 7;
  localparam int IMM_LOOP_W = 6;
  localparam int MASK8_W = 8;

  // Register selects driven out to the datapaths
  typedef enum logic [3:0] {
    REG_NONE, REG_ACC_A, REG_ACC_B, REG_ACC_A_MSP, REG_ACC_B_MSP, REG_DATA_X0, REG_DATA_Y0, REG_DATA_Y1,
    REG_PTR0, REG_PTR1, REG_PTR2, REG_PTR3, REG_STACK, REG_INDEX
  } reg_sel_t;

  // Which register field the current instruction carries
  typedef enum logic [2:0] {
    FIELD_NONE, FIELD_ALU_OPERAND, FIELD_PTR_OR_STACK, FIELD_PTR_ONLY, FIELD_ACC_PAIR, FIELD_MOVE_ALU_AGU
  } field_kind_t;

  // Which address or data operand form the instruction carries
  typedef enum logic [3:0] {
    OPND_NONE, OPND_IO_SHORT, OPND_ABS_SHORT, OPND_ABS_LONG, OPND_BRANCH, OPND_IMM_LOAD, OPND_IMM_LOOP,
    OPND_MASK_HIGH, OPND_MASK_LOW, OPND_IMM_LONG, OPND_MASK_LONG
  } opnd_kind_t;

  localparam logic [ADDR_W-1:0] ALL_ONES = 16'hFFFF;
  localparam logic [ADDR_W-1:0] ALL_ZEROS = 16'h0000;
endpackage : operand_decode_pkg

/* design/reg_field_map.sv */
module reg_field_map
  import operand_decode_pkg::*;
(
  input wire field_kind_t kind_i,
  input wire logic [3:0] code_i,
  input wire logic indexed_i,
  output reg_sel_t src_o,
  output reg_sel_t dst_o,
  output logic illegal_o
);
  function automatic reg_sel_t alu5(input logic [2:0] c);
    case (c)
      3'h0: alu5 = REG_ACC_A;
      3'h1: alu5 = REG_ACC_B;
      3'h4: alu5 = REG_DATA_X0;
      3'h5: alu5 = REG_DATA_Y0;
      3'h6: alu5 = REG_DATA_Y1;
      default: alu5 = REG_NONE;
    endcase
  endfunction : alu5

  function automatic reg_sel_t ptr4(input logic [1:0] c);
    ptr4 = reg_sel_t'(4'(REG_PTR0) + 4'(c));
  endfunction : ptr4

  wire reg_sel_t move_sel;
  // Codes 0-6 data ALU, 8-11 pointers, 12 index; 7,13-15 name nothing
  assign move_sel = (code_i[3:2] == 2'h2) ? ptr4(code_i[1:0]) : // RQ13
                    (code_i == 4'hC) ? REG_INDEX :
                    (code_i == 4'h2) ? REG_ACC_A_MSP :
                    (code_i == 4'h3) ? REG_ACC_B_MSP :
                    (code_i[3] == 1'b0) ? alu5(code_i[2:0]) : REG_NONE;

  always_comb begin
    src_o = REG_NONE;
    dst_o = REG_NONE;
    case (kind_i)
      FIELD_ALU_OPERAND: dst_o = (code_i[3] == 1'b0) ? alu5(code_i[2:0]) : REG_NONE; // RQ8
      FIELD_PTR_OR_STACK: dst_o = (code_i[3:2] == 2'h0) ? ptr4(code_i[1:0]) : // RQ9
                                  (code_i == 4'h4) ? REG_STACK : REG_NONE;
      FIELD_PTR_ONLY: dst_o = (code_i[3:2] == 2'h0) ? ptr4(code_i[1:0]) : REG_NONE; // RQ10
      FIELD_ACC_PAIR: begin
        if (code_i[3:1] == 3'h0) begin // RQ12
          src_o = code_i[0] ? REG_ACC_B : REG_ACC_A;
          dst_o = code_i[0] ? REG_ACC_A : REG_ACC_B;
        end
      end
      FIELD_MOVE_ALU_AGU: dst_o = (move_sel == REG_INDEX && !indexed_i) ? REG_NONE : move_sel; // RQ11
      default: dst_o = REG_NONE;
    endcase
  end

  assign illegal_o = (kind_i != FIELD_NONE) && (dst_o == REG_NONE); // RQ14
endmodule : reg_field_map

/* design/operand_field_decoder.sv */
module operand_field_decoder
  import operand_decode_pkg::*;
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic valid_i,
  input wire field_kind_t field_kind_i,
  input wire logic [3:0] reg_code_i,
  input wire logic indexed_mode_i,
  input wire opnd_kind_t opnd_kind_i,
  input wire logic [15:0] opnd_bits_i,
  input wire logic [15:0] pc_i,
  output reg_sel_t src_reg_o,
  output reg_sel_t dst_reg_o,
  output logic write_en_o,
  output logic illegal_o,
  output logic [15:0] address_o,
  output logic [15:0] data_o,
  output logic [15:0] branch_target_o,
  output logic valid_o
);
  reg_sel_t map_src;
  reg_sel_t map_dst;
  logic map_illegal;
  // Sampled reset keeps a request held through reset out of the checks
  wire decode_taken = valid_i && !sys_rst_i;

  reg_field_map u_map (
    .kind_i(field_kind_i),
    .code_i(reg_code_i),
    .indexed_i(indexed_mode_i),
    .src_o(map_src),
    .dst_o(map_dst),
    .illegal_o(map_illegal)
  );

  function automatic logic [15:0] sext7(input logic [BRANCH_OFS_W-1:0] v);
    sext7 = {{(ADDR_W - BRANCH_OFS_W){v[BRANCH_OFS_W-1]}}, v};
  endfunction : sext7

  wire [15:0] io_addr = {ALL_ONES[ADDR_W-1:SHORT_ADDR_W], opnd_bits_i[SHORT_ADDR_W-1:0]}; // RQ1
  wire [15:0] abs_addr = {ALL_ZEROS[ADDR_W-1:SHORT_ADDR_W], opnd_bits_i[SHORT_ADDR_W-1:0]}; // RQ2
  wire [15:0] target = pc_i + sext7(opnd_bits_i[BRANCH_OFS_W-1:0]); // RQ4
  // Load immediate is signed, loop counts are unsigned
  wire [15:0] imm_load = sext7(opnd_bits_i[IMM_LOAD_W-1:0]); // RQ5
  wire [15:0] imm_loop = {ALL_ZEROS[ADDR_W-1:IMM_LOOP_W], opnd_bits_i[IMM_LOOP_W-1:0]}; // RQ5
  wire [15:0] mask_hi = {opnd_bits_i[MASK8_W-1:0], ALL_ZEROS[MASK8_W-1:0]}; // RQ6
  wire [15:0] mask_lo = {ALL_ZEROS[MASK8_W-1:0], opnd_bits_i[MASK8_W-1:0]}; // RQ6

  logic [15:0] next_address;
  logic [15:0] next_data;
  always_comb begin
    next_address = address_o;
    next_data = data_o;
    case (opnd_kind_i)
      OPND_IO_SHORT: next_address = io_addr;
      OPND_ABS_SHORT: next_address = abs_addr;
      OPND_ABS_LONG: next_address = opnd_bits_i; // RQ3
      OPND_IMM_LOAD: next_data = imm_load;
      OPND_IMM_LOOP: next_data = imm_loop;
      OPND_MASK_HIGH: next_data = mask_hi;
      OPND_MASK_LOW: next_data = mask_lo;
      OPND_IMM_LONG, OPND_MASK_LONG: next_data = opnd_bits_i; // RQ7
      default: next_data = data_o;
    endcase
  end

  // Outputs registered so downstream units see one stable decode per cycle
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      src_reg_o <= REG_NONE;
      dst_reg_o <= REG_NONE;
      write_en_o <= 1'b0;
      illegal_o <= 1'b0;
      address_o <= ALL_ZEROS;
      data_o <= ALL_ZEROS;
      branch_target_o <= ALL_ZEROS;
      valid_o <= 1'b0;
    end else begin
      valid_o <= valid_i;
      illegal_o <= valid_i && map_illegal; // RQ14
      write_en_o <= valid_i && !map_illegal && field_kind_i != FIELD_NONE; // RQ14
      if (valid_i) begin
        src_reg_o <= map_src;
        dst_reg_o <= map_dst;
        address_o <= next_address;
        data_o <= next_data;
        if (opnd_kind_i == OPND_BRANCH) begin
          branch_target_o <= target;
        end
      end
    end
  end

  property p_io_short;
    @(posedge clock_i) disable iff (sys_rst_i)
    decode_taken && opnd_kind_i == OPND_IO_SHORT |=>
      address_o[15:6] == 10'h3FF && address_o[5:0] == $past(opnd_bits_i[5:0]);
  endproperty
  a_io_short: assert property (p_io_short) else $error("io short address not one-extended"); // RQ1

  property p_abs_short;
    @(posedge clock_i) disable iff (sys_rst_i)
    decode_taken && opnd_kind_i == OPND_ABS_SHORT |=> address_o == {10'h000, $past(opnd_bits_i[5:0])};
  endproperty
  a_abs_short: assert property (p_abs_short) else $error("abs short address not zero-extended"); // RQ2

  property p_abs_long;
    @(posedge clock_i) disable iff (sys_rst_i)
    decode_taken && opnd_kind_i == OPND_ABS_LONG |=> address_o == $past(opnd_bits_i);
  endproperty
  a_abs_long: assert property (p_abs_long) else $error("long address altered"); // RQ3

  property p_branch;
    @(posedge clock_i) disable iff (sys_rst_i)
    decode_taken && opnd_kind_i == OPND_BRANCH && opnd_bits_i[6:0] == 7'h7F |=>
      branch_target_o == $past(pc_i) - 16'h0001;
  endproperty
  a_branch: assert property (p_branch) else $error("branch offset not signed"); // RQ4

  property p_imm_loop;
    @(posedge clock_i) disable iff (sys_rst_i)
    decode_taken && opnd_kind_i == OPND_IMM_LOOP |=>
      data_o[15:6] == 10'h000 && data_o[5:0] == $past(opnd_bits_i[5:0]);
  endproperty
  a_imm_loop: assert property (p_imm_loop) else $error("loop immediate width wrong"); // RQ5

  property p_mask_hi;
    @(posedge clock_i) disable iff (sys_rst_i)
    decode_taken && opnd_kind_i == OPND_MASK_HIGH |=> data_o == {$past(opnd_bits_i[7:0]), 8'h00};
  endproperty
  a_mask_hi: assert property (p_mask_hi) else $error("upper mask misplaced"); // RQ6

  property p_imm_long;
    @(posedge clock_i) disable iff (sys_rst_i)
    decode_taken && opnd_kind_i == OPND_IMM_LONG |=> data_o == $past(opnd_bits_i);
  endproperty
  a_imm_long: assert property (p_imm_long) else $error("long immediate altered"); // RQ7

  property p_ptr_only;
    @(posedge clock_i) disable iff (sys_rst_i)
    decode_taken && field_kind_i == FIELD_PTR_ONLY |=> dst_reg_o != REG_STACK;
  endproperty
  a_ptr_only: assert property (p_ptr_only) else $error("stack pointer chosen by pointer-only field"); // RQ10

  property p_illegal;
    @(posedge clock_i) disable iff (sys_rst_i)
    illegal_o |-> !write_en_o && dst_reg_o == REG_NONE && src_reg_o == REG_NONE;
  endproperty
  a_illegal: assert property (p_illegal) else $error("write on illegal code"); // RQ14

  // Operand forms judged from the raw inputs, not from the decode wires
  property p_imm_load;
    @(posedge clock_i) disable iff (sys_rst_i)
    decode_taken && opnd_kind_i == OPND_IMM_LOAD |=>
      data_o == {{9{$past(opnd_bits_i[6])}}, $past(opnd_bits_i[6:0])};
  endproperty
  a_imm_load: assert property (p_imm_load) else $error("load immediate not taken from 7 bits"); // RQ5

  property p_mask_lo;
    @(posedge clock_i) disable iff (sys_rst_i)
    decode_taken && opnd_kind_i == OPND_MASK_LOW |=> data_o == {8'h00, $past(opnd_bits_i[7:0])};
  endproperty
  a_mask_lo: assert property (p_mask_lo) else $error("lower mask misplaced"); // RQ6

  property p_mask_long;
    @(posedge clock_i) disable iff (sys_rst_i)
    decode_taken && opnd_kind_i == OPND_MASK_LONG |=> data_o == $past(opnd_bits_i);
  endproperty
  a_mask_long: assert property (p_mask_long) else $error("long mask altered"); // RQ7

  property p_branch_sum;
    @(posedge clock_i) disable iff (sys_rst_i)
    decode_taken && opnd_kind_i == OPND_BRANCH |=>
      branch_target_o == $past(pc_i) + {{9{$past(opnd_bits_i[6])}}, $past(opnd_bits_i[6:0])};
  endproperty
  a_branch_sum: assert property (p_branch_sum) else $error("branch target wrong"); // RQ4

  property p_branch_hold;
    @(posedge clock_i) disable iff (sys_rst_i)
    decode_taken && opnd_kind_i != OPND_BRANCH |=> $stable(branch_target_o);
  endproperty
  a_branch_hold: assert property (p_branch_hold) else $error("branch target moved without a branch"); // RQ4

  property p_addr_hold;
    @(posedge clock_i) disable iff (sys_rst_i)
    decode_taken && !(opnd_kind_i inside {OPND_IO_SHORT, OPND_ABS_SHORT, OPND_ABS_LONG}) |=>
      $stable(address_o);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved without an address form"); // RQ3

  property p_alu_set;
    @(posedge clock_i) disable iff (sys_rst_i)
    decode_taken && field_kind_i == FIELD_ALU_OPERAND |=>
      dst_reg_o inside {REG_NONE, REG_ACC_A, REG_ACC_B, REG_DATA_X0, REG_DATA_Y0, REG_DATA_Y1};
  endproperty
  a_alu_set: assert property (p_alu_set) else $error("arithmetic field left its set"); // RQ8

  property p_alu_x0;
    @(posedge clock_i) disable iff (sys_rst_i)
    decode_taken && field_kind_i == FIELD_ALU_OPERAND && reg_code_i == 4'h4 |=> dst_reg_o == REG_DATA_X0;
  endproperty
  a_alu_x0: assert property (p_alu_x0) else $error("arithmetic field code 4 not first data register"); // RQ8

  property p_ptr_set;
    @(posedge clock_i) disable iff (sys_rst_i)
    decode_taken && field_kind_i == FIELD_PTR_OR_STACK |=>
      dst_reg_o inside {REG_NONE, REG_PTR0, REG_PTR1, REG_PTR2, REG_PTR3, REG_STACK};
  endproperty
  a_ptr_set: assert property (p_ptr_set) else $error("pointer field left its set"); // RQ9

  property p_stack;
    @(posedge clock_i) disable iff (sys_rst_i)
    decode_taken && field_kind_i == FIELD_PTR_OR_STACK && reg_code_i == 4'h4 |=> dst_reg_o == REG_STACK;
  endproperty
  a_stack: assert property (p_stack) else $error("stack pointer not selected"); // RQ9

  property p_ptr_only_bad;
    @(posedge clock_i) disable iff (sys_rst_i)
    decode_taken && field_kind_i == FIELD_PTR_ONLY && reg_code_i[3:2] != 2'h0 |=> illegal_o && !write_en_o;
  endproperty
  a_ptr_only_bad: assert property (p_ptr_only_bad) else $error("pointer-only field took a bad code"); // RQ10

  property p_index_only;
    @(posedge clock_i) disable iff (sys_rst_i)
    decode_taken && !indexed_mode_i |=> dst_reg_o != REG_INDEX;
  endproperty
  a_index_only: assert property (p_index_only) else $error("index register outside indexed mode"); // RQ11

  property p_pair;
    @(posedge clock_i) disable iff (sys_rst_i)
    decode_taken && field_kind_i == FIELD_ACC_PAIR && reg_code_i[3:1] == 3'h0 |=>
      src_reg_o inside {REG_ACC_A, REG_ACC_B} && dst_reg_o inside {REG_ACC_A, REG_ACC_B} && src_reg_o != dst_reg_o;
  endproperty
  a_pair: assert property (p_pair) else $error("accumulator pair not two accumulators"); // RQ12

  property p_pair_bad;
    @(posedge clock_i) disable iff (sys_rst_i)
    decode_taken && field_kind_i == FIELD_ACC_PAIR && reg_code_i[3:1] != 3'h0 |=>
      illegal_o && src_reg_o == REG_NONE;
  endproperty
  a_pair_bad: assert property (p_pair_bad) else $error("bad accumulator pair accepted"); // RQ12

  property p_move_set;
    @(posedge clock_i) disable iff (sys_rst_i)
    decode_taken && field_kind_i == FIELD_MOVE_ALU_AGU |=> dst_reg_o != REG_STACK;
  endproperty
  a_move_set: assert property (p_move_set) else $error("move field chose the stack pointer"); // RQ13

  property p_move_msp;
    @(posedge clock_i) disable iff (sys_rst_i)
    decode_taken && field_kind_i == FIELD_MOVE_ALU_AGU && reg_code_i == 4'h2 |=> dst_reg_o == REG_ACC_A_MSP;
  endproperty
  a_move_msp: assert property (p_move_msp) else $error("move field code 2 not upper accumulator part"); // RQ13

  property p_write_legal;
    @(posedge clock_i) disable iff (sys_rst_i)
    decode_taken && field_kind_i != FIELD_NONE |=> write_en_o != illegal_o;
  endproperty
  a_write_legal: assert property (p_write_legal) else $error("write and illegal flags disagree"); // RQ14

  property p_idle_quiet;
    @(posedge clock_i) disable iff (sys_rst_i)
    !valid_i |=> !valid_o && !write_en_o && !illegal_o;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("strobe without a request"); // RQ14

  c_branch: cover property (@(posedge clock_i) valid_i && opnd_kind_i == OPND_BRANCH);
  c_illegal: cover property (@(posedge clock_i) illegal_o);
  c_pair: cover property (@(posedge clock_i) valid_i && field_kind_i == FIELD_ACC_PAIR);
  c_index: cover property (@(posedge clock_i) valid_i && field_kind_i == FIELD_MOVE_ALU_AGU && indexed_mode_i);
  c_stack: cover property (@(posedge clock_i) valid_i && field_kind_i == FIELD_PTR_OR_STACK && reg_code_i == 4'h4);
endmodule : operand_field_decoder

/* test/fetch_stub.sv */
module fetch_stub
  import operand_decode_pkg::*;
(
  output logic valid_o,
  output field_kind_t kind_o,
  output logic [3:0] code_o,
  output logic indexed_o,
  output opnd_kind_t opnd_o,
  output logic [15:0] bits_o,
  output logic [15:0] pc_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    valid_o = 1'b0;
    kind_o = FIELD_NONE;
    code_o = 4'h0;
    indexed_o = 1'b0;
    opnd_o = OPND_NONE;
    bits_o = 16'h0000;
    pc_o = 16'h0000;
  end
  // Called at a rising edge; fields change together and hold until the next call
  task issue(input field_kind_t k, input logic [3:0] c, input logic x, input opnd_kind_t o,
             input logic [15:0] b, input logic [15:0] p);
    valid_o <= 1'b1;
    kind_o <= k;
    code_o <= c;
    indexed_o <= x;
    opnd_o <= o;
    bits_o <= b;
    pc_o <= p;
  endtask : issue
  // Stale code, operand bits and pc are scrambled so the decoder cannot lean on leftovers
  task idle();
    valid_o <= 1'b0;
    code_o <= ~code_o;
    bits_o <= ~bits_o;
    pc_o <= ~pc_o;
  endtask : idle
endmodule : fetch_stub

/* test/test_operand_field_decoder.sv */
module test_operand_field_decoder
  import operand_decode_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {field_kind_t fk; logic [3:0] c; logic x; opnd_kind_t ok; logic [15:0] b; logic [15:0] p;
    reg_sel_t src; reg_sel_t dst; int we; int ill; logic [15:0] v;} row_t;
  localparam int N = 24;
  row_t rows [N] = '{
    '{FIELD_ALU_OPERAND, 4'h0, 1'b0, OPND_IO_SHORT, 16'h0005, 16'h0, REG_NONE, REG_ACC_A, 1, 0, 16'hFFC5},
    '{FIELD_ALU_OPERAND, 4'h1, 1'b0, OPND_ABS_SHORT, 16'hFFFF, 16'h0, REG_NONE, REG_ACC_B, 1, 0, 16'h003F},
    '{FIELD_MOVE_ALU_AGU, 4'h2, 1'b0, OPND_NONE, 16'h0, 16'h0, REG_NONE, REG_ACC_A_MSP, 1, 0, 16'h0},
    '{FIELD_MOVE_ALU_AGU, 4'h9, 1'b0, OPND_IMM_LOAD, 16'h003F, 16'h0, REG_NONE, REG_PTR1, 1, 0, 16'h003F},
    '{FIELD_MOVE_ALU_AGU, 4'hB, 1'b0, OPND_IO_SHORT, 16'h002A, 16'h0, REG_NONE, REG_PTR3, 1, 0, 16'hFFEA},
    '{FIELD_PTR_OR_STACK, 4'h0, 1'b0, OPND_ABS_SHORT, 16'hFFE1, 16'h0, REG_NONE, REG_PTR0, 1, 0, 16'h0021},
    '{FIELD_MOVE_ALU_AGU, 4'hD, 1'b0, OPND_NONE, 16'h0, 16'h0, REG_NONE, REG_NONE, 0, 1, 16'h0},
    '{FIELD_ALU_OPERAND, 4'h4, 1'b0, OPND_ABS_LONG, 16'h1234, 16'h0, REG_NONE, REG_DATA_X0, 1, 0, 16'h1234},
    '{FIELD_ALU_OPERAND, 4'h5, 1'b0, OPND_BRANCH, 16'h003F, 16'h0100, REG_NONE, REG_DATA_Y0, 1, 0, 16'h013F},
    '{FIELD_ALU_OPERAND, 4'h6, 1'b0, OPND_BRANCH, 16'h0040, 16'h0010, REG_NONE, REG_DATA_Y1, 1, 0, 16'hFFD0},
    '{FIELD_ALU_OPERAND, 4'h3, 1'b0, OPND_NONE, 16'h0, 16'h0, REG_NONE, REG_NONE, 0, 1, 16'h0},
    '{FIELD_PTR_OR_STACK, 4'h4, 1'b0, OPND_IMM_LOAD, 16'h0040, 16'h0, REG_NONE, REG_STACK, 1, 0, 16'hFFC0},
    '{FIELD_PTR_OR_STACK, 4'h5, 1'b0, OPND_NONE, 16'h0, 16'h0, REG_NONE, REG_NONE, 0, 1, 16'h0},
    '{FIELD_PTR_ONLY, 4'h3, 1'b0, OPND_IMM_LOOP, 16'hFFFF, 16'h0, REG_NONE, REG_PTR3, 1, 0, 16'h003F},
    '{FIELD_PTR_ONLY, 4'h4, 1'b0, OPND_NONE, 16'h0, 16'h0, REG_NONE, REG_NONE, 0, 1, 16'h0},
    '{FIELD_ACC_PAIR, 4'h0, 1'b0, OPND_MASK_HIGH, 16'h00A5, 16'h0, REG_ACC_A, REG_ACC_B, 1, 0, 16'hA500},
    '{FIELD_ACC_PAIR, 4'h1, 1'b0, OPND_MASK_LOW, 16'hFFA5, 16'h0, REG_ACC_B, REG_ACC_A, 1, 0, 16'h00A5},
    '{FIELD_ACC_PAIR, 4'h2, 1'b0, OPND_NONE, 16'h0, 16'h0, REG_NONE, REG_NONE, 0, 1, 16'h0},
    '{FIELD_MOVE_ALU_AGU, 4'h3, 1'b0, OPND_IMM_LONG, 16'hBEEF, 16'h0, REG_NONE, REG_ACC_B_MSP, 1, 0, 16'hBEEF},
    '{FIELD_MOVE_ALU_AGU, 4'h8, 1'b0, OPND_MASK_LONG, 16'h8001, 16'h0, REG_NONE, REG_PTR0, 1, 0, 16'h8001},
    '{FIELD_MOVE_ALU_AGU, 4'hC, 1'b1, OPND_NONE, 16'h0, 16'h0, REG_NONE, REG_INDEX, 1, 0, 16'h0},
    '{FIELD_MOVE_ALU_AGU, 4'hC, 1'b0, OPND_NONE, 16'h0, 16'h0, REG_NONE, REG_NONE, 0, 1, 16'h0},
    '{FIELD_MOVE_ALU_AGU, 4'h7, 1'b0, OPND_NONE, 16'h0, 16'h0, REG_NONE, REG_NONE, 0, 1, 16'h0},
    '{FIELD_NONE, 4'h0, 1'b0, OPND_NONE, 16'h0, 16'h0, REG_NONE, REG_NONE, 0, 0, 16'h0}};
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic valid_i, indexed_mode_i, write_en_o, illegal_o, valid_o;
  field_kind_t field_kind_i;
  opnd_kind_t opnd_kind_i;
  logic [3:0] reg_code_i;
  logic [15:0] opnd_bits_i, pc_i, address_o, data_o, branch_target_o;
  reg_sel_t src_reg_o, dst_reg_o;
  int checks = 0;
  int failures = 0;
  always #10 clock_i = ~clock_i;
  fetch_stub f (.valid_o(valid_i), .kind_o(field_kind_i), .code_o(reg_code_i), .indexed_o(indexed_mode_i),
    .opnd_o(opnd_kind_i), .bits_o(opnd_bits_i), .pc_o(pc_i));
  operand_field_decoder dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .valid_i(valid_i),
    .field_kind_i(field_kind_i), .reg_code_i(reg_code_i), .indexed_mode_i(indexed_mode_i),
    .opnd_kind_i(opnd_kind_i), .opnd_bits_i(opnd_bits_i), .pc_i(pc_i), .src_reg_o(src_reg_o),
    .dst_reg_o(dst_reg_o), .write_en_o(write_en_o), .illegal_o(illegal_o), .address_o(address_o),
    .data_o(data_o), .branch_target_o(branch_target_o), .valid_o(valid_o));
  task cmp(input string name, input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp
  task zeros();
    cmp("valid_o", 16'(valid_o), 16'h0000);
    cmp("flags", 16'({write_en_o, illegal_o}), 16'h0000);
    cmp("regs", 16'({src_reg_o, dst_reg_o}), 16'h0000);
    cmp("operands", address_o | data_o | branch_target_o, 16'h0000);
  endtask : zeros
  task check(input row_t r);
    logic [15:0] seen;
    seen = (r.ok inside {OPND_IO_SHORT, OPND_ABS_SHORT, OPND_ABS_LONG}) ? address_o :
           (r.ok == OPND_BRANCH) ? branch_target_o : data_o;
    cmp("valid_o", 16'(valid_o), 16'h0001);
    cmp("write_en_o", 16'(write_en_o), 16'(r.we));
    cmp("illegal_o", 16'(illegal_o), 16'(r.ill));
    cmp("dst_reg_o", 16'(dst_reg_o), 16'(r.dst));
    cmp("src_reg_o", 16'(src_reg_o), 16'(r.src));
    if (r.ok != OPND_NONE) cmp("operand", seen, r.v);
  endtask : check
  task results();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  initial begin
    // A request held during reset must leave no trace
    @(posedge clock_i);
    f.issue(FIELD_ALU_OPERAND, 4'h0, 1'b0, OPND_IO_SHORT, 16'h0005, 16'h0);
    repeat (4) @(posedge clock_i);
    @(negedge clock_i);
    zeros();
    @(posedge clock_i);
    sys_rst_i <= 1'b0;
    f.idle();
    // Back to back: row i goes in while row i-1 is checked
    for (int i = 0; i <= N; i++) begin
      @(posedge clock_i);
      if (i < N) f.issue(rows[i].fk, rows[i].c, rows[i].x, rows[i].ok, rows[i].b, rows[i].p);
      else f.idle();
      @(negedge clock_i);
      if (i > 0) check(rows[i-1]);
    end
    @(posedge clock_i);
    @(negedge clock_i);
    cmp("strobes", 16'({valid_o, write_en_o, illegal_o}), 16'h0000);
    cmp("address_o", address_o, 16'h1234);
    cmp("data_o", data_o, 16'h8001);
    cmp("branch_target_o", branch_target_o, 16'hFFD0);
    @(posedge clock_i);
    sys_rst_i <= 1'b1;
    f.issue(FIELD_PTR_ONLY, 4'h1, 1'b0, OPND_ABS_LONG, 16'h5555, 16'h0);
    @(posedge clock_i);
    @(negedge clock_i);
    zeros();
    // Request still held at release is taken on the first edge after it
    @(posedge clock_i);
    sys_rst_i <= 1'b0;
    @(posedge clock_i);
    f.idle();
    @(negedge clock_i);
    cmp("valid_o", 16'(valid_o), 16'h0001);
    cmp("dst_reg_o", 16'(dst_reg_o), 16'(REG_PTR1));
    cmp("address_o", address_o, 16'h5555);
    results();
  end
endmodule : test_operand_field_decoder
